// ### logic/input_sync.sv
`timescale 1ns/100ps
module input_sync #(
  parameter int W = 4
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // input_sync

// ### logic/pause_if.sv
`timescale 1ns/100ps
interface pause_if;
  logic        start;
  logic        abort;
  logic [21:0] ms;
  logic        done;
  modport timer (input start, input abort, input ms, output done);
  modport ctrl  (output start, output abort, output ms, input done);
endinterface

// ### logic/pause_timer.sv
`timescale 1ns/100ps
`include "step_exec_params.svh"
module pause_timer #(
  parameter int unsigned MS_CYCLES = `MS_NS / `CLK_PERIOD_NS
) (
  input wire logic aclk,
  input wire logic aresetn,
  pause_if.timer   pt
);
  localparam int CW = $clog2(MS_CYCLES + 1);
  logic [CW-1:0]      cyc;
  logic [`DATA_W-1:0] left;
  logic               run;

  // millisecond countdown, abort wins over everything
  always_ff @(posedge aclk) begin
    if (!aresetn || pt.abort) begin
      run     <= 1'h0;
      left    <= '0;
      cyc     <= '0;
      pt.done <= 1'h0;
    end else begin
      pt.done <= 1'h0;
      if (pt.start) begin
        run  <= 1'h1;
        left <= pt.ms;
        cyc  <= '0;
      end else if (run) begin
        if (left == '0) begin
          run     <= 1'h0;
          pt.done <= 1'h1;
        end else if (cyc == CW'(MS_CYCLES - 1)) begin
          cyc  <= '0;
          left <= left - 1'h1;
        end else begin
          cyc <= cyc + 1'h1;
        end
      end
    end
  end
endmodule // pause_timer

// ### logic/step_exec_params.svh
`ifndef STEP_EXEC_PARAMS_SVH
`define STEP_EXEC_PARAMS_SVH
// instruction word layout
`define OP_W          8
`define DATA_W        22
`define CMD_OP_HI     29
`define CMD_OP_LO     22
// opcodes
`define OP_MASK       8'h0a
`define OP_RUN_F      8'h0e
`define OP_RUN_R_DEF  8'h0f
`define OP_MOVE_F     8'h10
`define OP_MOVE_R_DEF 8'h11
`define OP_ABS_F      8'h12
`define OP_ABS_R      8'h13
`define OP_UNTIL_F    8'h14
`define OP_UNTIL_R    8'h15
`define OP_ZERO_F     8'h16
`define OP_ZERO_R     8'h17
`define OP_MARK_F     8'h18
`define OP_MARK_R     8'h19
`define OP_GO_ZERO    8'h1a
`define OP_GO_MARK    8'h1b
`define OP_SHORTEST   8'h1c
`define OP_POS_CLR    8'h1d
`define OP_MOD_RST    8'h1e
`define OP_SOFT_STOP  8'h1f
`define OP_ABRUPT_HOLD_CMD  8'h20
`define OP_DECEL_REL  8'h21
`define OP_ABRUPT_REL 8'h22
`define OP_PAUSE      8'h23
`define OP_RELAY_ON   8'h24
`define OP_RELAY_OFF  8'h25
`define OP_AWAIT_A    8'h27
`define OP_AWAIT_B    8'h28
// operand limits
`define SPEED_MIN     22'h00000f
`define SPEED_MAX     22'h003cf0
`define PAUSE_MAX     22'h36ee80
// register byte offsets, address width and bus response codes
`define ADDR_W        4
`define REG_CMD       4'h0
`define REG_STATUS    4'h4
`define REG_MASK      4'h8
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2
// status bits
`define ST_BUSY       0
`define ST_MOTOR      1
`define ST_RELAY      2
`define ST_ERR_OP     8
`define ST_ERR_RANGE  9
`define ST_ERR_BUSY   10
// input mask
`define MASK_RESET    8'hff
`define IN_A          2'h0
`define IN_B          2'h1
`define IN_ZERO       2'h2
`define IN_LIM        2'h3
// timing
`define CLK_PERIOD_NS 8
`define MS_NS         1000000
`endif

// ### logic/step_exec_pkg.sv
package step_exec_pkg;
  typedef enum logic [3:0] {
    ACT_RUN          = 4'h0,
    ACT_MOVE         = 4'h1,
    ACT_GOTO         = 4'h2,
    ACT_GOTO_SHORT   = 4'h3,
    ACT_UNTIL_SW     = 4'h4,
    ACT_GO_ZERO      = 4'h5,
    ACT_GO_MARK      = 4'h6,
    ACT_SOFT_STOP    = 4'h7,
    ACT_ABRUPT_HOLD_CMD    = 4'h8,
    ACT_DECEL_REL    = 4'h9,
    ACT_ABRUPT_REL   = 4'ha
  } motion_action_t;
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_PAUSE  = 4'b0010,
    ST_AWAIT  = 4'b0100,
    ST_SEARCH = 4'b1000
  } exec_state_t;
endpackage

// ### logic/stepper_motion_cmd_executor.sv
// Operation
// - opcode 0x0e runs forward continuously at data-field speed, 15 to 15600.
// - reverse run spins backward at data-field speed, same range.
// - speed operands are full steps per second, whatever the microstepping.
// - opcode 0x10 moves forward by signed 22-bit displacement using configured profile.
// - reverse move displaces backward by same signed range and profile.
// - displacement and position operands count microsteps.
// - opcode 0x12 goes forward to absolute data-field position.
// - opcode 0x13 goes backward to absolute data-field position.
// - opcodes 0x14/0x15 run at max speed until unmasked limit switch, then stop.
// - opcodes 0x16/0x17 search zero at data speed until zero input.
// - opcodes 0x18/0x19 search mark at data speed until input b.
// - opcode 0x1a goes to stored zero, 0x1b to stored mark.
// - opcode 0x1c goes to absolute position by shorter direction.
// - opcode 0x1d clears step counter, present position becomes zero.
// - opcode 0x1e resets only the motion module; the executor also ends any pause, input wait or search in progress.
// - opcode 0x1f decelerates to standstill and holds.
// - opcode 0x20 stops at once and holds.
// - opcode 0x21 decelerates then releases, 0x22 stops and releases at once.
// - opcode 0x23 pauses for data-field milliseconds, 0 to 3600000.
// - opcode 0x24 switches relay on, 0x25 off.
// - opcode 0x27 waits for input a, 0x28 for input b.
// - a physical input counts only while its mask bit is one.
// - opcode 0x0a loads eight mask bits from data bits 7..0.
//
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/100ps
`include "step_exec_params.svh"
module stepper_motion_cmd_executor #(
  parameter logic [7:0]  OP_RUN_R  = `OP_RUN_R_DEF,
  parameter logic [7:0]  OP_MOVE_R = `OP_MOVE_R_DEF,
  parameter int unsigned MS_CYCLES = `MS_NS / `CLK_PERIOD_NS
) (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic [`ADDR_W-1:0] awaddr,
  input  wire logic               awvalid,
  output logic                    awready,
  input  wire logic [31:0]        wdata,
  input  wire logic [3:0]         wstrb,
  input  wire logic               wvalid,
  output logic                    wready,
  output logic [1:0]              bresp,
  output logic                    bvalid,
  input  wire logic               bready,
  input  wire logic [`ADDR_W-1:0] araddr,
  input  wire logic               arvalid,
  output logic                    arready,
  output logic [31:0]             rdata,
  output logic [1:0]              rresp,
  output logic                    rvalid,
  input  wire logic               rready,
  input  wire logic               motor_busy,
  output logic                    motion_start,
  output logic [3:0]              motion_action,
  output logic                    motion_reverse,
  output logic [`DATA_W-1:0]      motion_operand,
  output logic                    position_clear,
  output logic                    module_reset,
  output logic                    relay_out,
  input  wire logic               limit_switch_input,
  input  wire logic               zero_input,
  input  wire logic               digital_input_a,
  input  wire logic               digital_input_b
);
  step_exec_pkg::exec_state_t    state;
  step_exec_pkg::exec_state_t    next_state;
  step_exec_pkg::motion_action_t d_action;
  logic [3:0]         pins_s;
  logic [3:0]         pins_live;
  logic [7:0]         mask;
  logic [1:0]         watch;
  logic [1:0]         next_watch;
  logic               wr_go;
  logic               rd_go;
  logic               cmd_wr;
  logic               accept;
  logic [`OP_W-1:0]   cmd_op;
  logic [`DATA_W-1:0] cmd_data;
  logic [31:0]        last_cmd;
  logic               stop_class;
  logic               d_issue;
  logic               d_rev;
  logic               d_bad;
  logic               d_range;
  logic               d_mask;
  logic               d_pos_clr;
  logic               d_mod_rst;
  logic               d_relay_on;
  logic               d_relay_off;
  logic               speed_bad;
  logic               err_op;
  logic               err_range;
  logic               err_busy;
  logic               set_op;
  logic               set_range;
  logic               set_busy;
  logic               clr_st;
  logic               hit;
  logic               search_hit;
  logic [31:0]        status;
  pause_if            pz ();

  input_sync #(.W(4)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({limit_switch_input, zero_input, digital_input_b, digital_input_a}),
    .q       (pins_s)
  );

  pause_timer #(.MS_CYCLES(MS_CYCLES)) u_pause (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pt      (pz.timer)
  );

  // inputs gated by their mask bits
  assign pins_live  = pins_s & mask[3:0];
  assign hit        = pins_live[watch];
  assign search_hit = (state == step_exec_pkg::ST_SEARCH) && hit;

  // bus handshakes
  assign wr_go   = awvalid && wvalid && !bvalid;
  assign awready = wr_go;
  assign wready  = wr_go;
  assign rd_go   = arvalid && !rvalid;
  assign arready = rd_go;
  assign cmd_wr  = wr_go && (awaddr == `REG_CMD) && (wstrb == 4'hf);
  assign clr_st  = wr_go && (awaddr == `REG_STATUS) && wstrb[1];

  // instruction fields
  assign cmd_op   = wdata[`CMD_OP_HI:`CMD_OP_LO];
  assign cmd_data = wdata[`DATA_W-1:0];
  assign stop_class = (cmd_op >= `OP_MOD_RST) && (cmd_op <= `OP_ABRUPT_REL);
  assign accept     = cmd_wr && (state == step_exec_pkg::ST_IDLE || stop_class);
  assign speed_bad  = (cmd_data < `SPEED_MIN) || (cmd_data > `SPEED_MAX);

  // instruction decode
  always_comb begin
    d_issue     = 1'h0;
    d_action    = step_exec_pkg::ACT_SOFT_STOP;
    d_rev       = 1'h0;
    d_bad       = 1'h0;
    d_range     = 1'h0;
    d_mask      = 1'h0;
    d_pos_clr   = 1'h0;
    d_mod_rst   = 1'h0;
    d_relay_on  = 1'h0;
    d_relay_off = 1'h0;
    next_state  = step_exec_pkg::ST_IDLE;
    next_watch  = `IN_A;
    case (cmd_op)
      `OP_MASK: d_mask = 1'h1;
      `OP_RUN_F, OP_RUN_R: begin
        d_issue  = 1'h1;
        d_action = step_exec_pkg::ACT_RUN;
        d_rev    = (cmd_op == OP_RUN_R);
        d_range  = speed_bad;
      end
      `OP_MOVE_F, OP_MOVE_R: begin
        d_issue  = 1'h1;
        d_action = step_exec_pkg::ACT_MOVE;
        d_rev    = (cmd_op == OP_MOVE_R);
      end
      `OP_ABS_F, `OP_ABS_R: begin
        d_issue  = 1'h1;
        d_action = step_exec_pkg::ACT_GOTO;
        d_rev    = (cmd_op == `OP_ABS_R);
      end
      `OP_SHORTEST: begin
        d_issue  = 1'h1;
        d_action = step_exec_pkg::ACT_GOTO_SHORT;
      end
      `OP_UNTIL_F, `OP_UNTIL_R: begin
        d_issue    = 1'h1;
        d_action   = step_exec_pkg::ACT_UNTIL_SW;
        d_rev      = (cmd_op == `OP_UNTIL_R);
        next_state = step_exec_pkg::ST_SEARCH;
        next_watch = `IN_LIM;
      end
      `OP_ZERO_F, `OP_ZERO_R: begin
        d_issue    = 1'h1;
        d_action   = step_exec_pkg::ACT_RUN;
        d_rev      = (cmd_op == `OP_ZERO_R);
        d_range    = speed_bad;
        next_state = step_exec_pkg::ST_SEARCH;
        next_watch = `IN_ZERO;
      end
      `OP_MARK_F, `OP_MARK_R: begin
        d_issue    = 1'h1;
        d_action   = step_exec_pkg::ACT_RUN;
        d_rev      = (cmd_op == `OP_MARK_R);
        d_range    = speed_bad;
        next_state = step_exec_pkg::ST_SEARCH;
        next_watch = `IN_B;
      end
      `OP_GO_ZERO: begin
        d_issue  = 1'h1;
        d_action = step_exec_pkg::ACT_GO_ZERO;
      end
      `OP_GO_MARK: begin
        d_issue  = 1'h1;
        d_action = step_exec_pkg::ACT_GO_MARK;
      end
      `OP_POS_CLR: d_pos_clr = 1'h1;
      `OP_MOD_RST: d_mod_rst = 1'h1;
      `OP_SOFT_STOP: begin
        d_issue  = 1'h1;
        d_action = step_exec_pkg::ACT_SOFT_STOP;
      end
      `OP_ABRUPT_HOLD_CMD: begin
        d_issue  = 1'h1;
        d_action = step_exec_pkg::ACT_ABRUPT_HOLD_CMD;
      end
      `OP_DECEL_REL: begin
        d_issue  = 1'h1;
        d_action = step_exec_pkg::ACT_DECEL_REL;
      end
      `OP_ABRUPT_REL: begin
        d_issue  = 1'h1;
        d_action = step_exec_pkg::ACT_ABRUPT_REL;
      end
      `OP_PAUSE: begin
        d_range    = (cmd_data > `PAUSE_MAX);
        next_state = step_exec_pkg::ST_PAUSE;
      end
      `OP_RELAY_ON:  d_relay_on  = 1'h1;
      `OP_RELAY_OFF: d_relay_off = 1'h1;
      `OP_AWAIT_A: begin
        next_state = step_exec_pkg::ST_AWAIT;
        next_watch = `IN_A;
      end
      `OP_AWAIT_B: begin
        next_state = step_exec_pkg::ST_AWAIT;
        next_watch = `IN_B;
      end
      default: d_bad = 1'h1;
    endcase
  end

  assign set_op    = accept && d_bad;
  assign set_range = accept && d_range;
  assign set_busy  = cmd_wr && !accept;

  // sequencer: pause, input wait and search tracking
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= step_exec_pkg::ST_IDLE;
      watch <= `IN_A;
    end else if (accept && !d_bad && !d_range) begin
      state <= next_state;
      watch <= next_watch;
    end else begin
      case (state)
        step_exec_pkg::ST_IDLE:   state <= step_exec_pkg::ST_IDLE;
        step_exec_pkg::ST_PAUSE:  if (pz.done) state <= step_exec_pkg::ST_IDLE;
        step_exec_pkg::ST_AWAIT:  if (hit) state <= step_exec_pkg::ST_IDLE;
        step_exec_pkg::ST_SEARCH: if (hit) state <= step_exec_pkg::ST_IDLE;
        default:                  state <= step_exec_pkg::ST_IDLE;
      endcase
    end
  end

  // pause timer control
  assign pz.start = accept && !d_range && (cmd_op == `OP_PAUSE);
  assign pz.ms    = cmd_data;
  assign pz.abort = accept && stop_class;

  // motion module request, search end issues a decelerating stop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      motion_start   <= 1'h0;
      motion_action  <= step_exec_pkg::ACT_SOFT_STOP;
      motion_reverse <= 1'h0;
      motion_operand <= '0;
    end else if (accept && d_issue && !d_range) begin
      motion_start   <= 1'h1;
      motion_action  <= d_action;
      motion_reverse <= d_rev;
      motion_operand <= cmd_data;
    end else if (search_hit) begin
      motion_start  <= 1'h1;
      motion_action <= step_exec_pkg::ACT_SOFT_STOP;
    end else begin
      motion_start <= 1'h0;
    end
  end

  // single-cycle control strobes to the motion module
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      position_clear <= 1'h0;
      module_reset   <= 1'h0;
    end else begin
      position_clear <= accept && d_pos_clr;
      module_reset   <= accept && d_mod_rst;
    end
  end

  // relay output
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      relay_out <= 1'h0;
    end else if (accept && d_relay_on) begin
      relay_out <= 1'h1;
    end else if (accept && d_relay_off) begin
      relay_out <= 1'h0;
    end
  end

  // input mask, loaded by opcode or by direct register write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask <= `MASK_RESET;
    end else if (accept && d_mask) begin
      mask <= cmd_data[7:0];
    end else if (wr_go && (awaddr == `REG_MASK) && wstrb[0]) begin
      mask <= wdata[7:0];
    end
  end

  // sticky errors, write one to clear, a new event wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_op    <= 1'h0;
      err_range <= 1'h0;
      err_busy  <= 1'h0;
    end else begin
      err_op    <= set_op || (err_op && !(clr_st && wdata[`ST_ERR_OP]));
      err_range <= set_range || (err_range && !(clr_st && wdata[`ST_ERR_RANGE]));
      err_busy  <= set_busy || (err_busy && !(clr_st && wdata[`ST_ERR_BUSY]));
    end
  end

  // last instruction written
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_cmd <= '0;
    end else if (cmd_wr) begin
      last_cmd <= wdata;
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'h0;
      bresp  <= `RESP_OKAY;
    end else if (wr_go) begin
      bvalid <= 1'h1;
      if (awaddr == `REG_CMD || awaddr == `REG_STATUS || awaddr == `REG_MASK) begin
        bresp <= `RESP_OKAY;
      end else begin
        bresp <= `RESP_SLVERR;
      end
    end else if (bready) begin
      bvalid <= 1'h0;
    end
  end

  // status word
  always_comb begin
    status                = '0;
    status[`ST_BUSY]      = (state != step_exec_pkg::ST_IDLE);
    status[`ST_MOTOR]     = motor_busy;
    status[`ST_RELAY]     = relay_out;
    status[`ST_ERR_OP]    = err_op;
    status[`ST_ERR_RANGE] = err_range;
    status[`ST_ERR_BUSY]  = err_busy;
  end

  // read response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'h0;
      rdata  <= '0;
      rresp  <= `RESP_OKAY;
    end else if (rd_go) begin
      rvalid <= 1'h1;
      rresp  <= `RESP_OKAY;
      case (araddr)
        `REG_CMD:    rdata <= last_cmd;
        `REG_STATUS: rdata <= status;
        `REG_MASK:   rdata <= {24'h000000, mask};
        default: begin
          rdata <= '0;
          rresp <= `RESP_SLVERR;
        end
      endcase
    end else if (rready) begin
      rvalid <= 1'h0;
    end
  end
endmodule // stepper_motion_cmd_executor

// ### tb/motion_model.sv
`timescale 1ns/100ps
module motion_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       motion_start,
  input  wire logic [3:0] motion_action,
  input  wire logic       slow,
  output logic            motor_busy
);
  logic [4:0] left;
  // abrupt stops end motion at once, all else runs a while
  always_ff @(posedge aclk) begin
    if (!aresetn) left <= 5'h0;
    else if (motion_start && (motion_action == step_exec_pkg::ACT_ABRUPT_HOLD_CMD ||
             motion_action == step_exec_pkg::ACT_ABRUPT_REL)) left <= 5'h0;
    else if (motion_start) left <= slow ? 5'h14 : 5'h2;
    else if (left != 5'h0) left <= left - 5'h1;
  end
  assign motor_busy = left != 5'h0;
endmodule // motion_model

// ### tb/stepper_motion_cmd_executor_checker.sv
`timescale 1ns/100ps
`include "step_exec_params.svh"
module stepper_motion_cmd_executor_checker (
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire logic [`ADDR_W-1:0] awaddr,
  input wire logic               awvalid,
  input wire logic               awready,
  input wire logic [31:0]        wdata,
  input wire logic [3:0]         wstrb,
  input wire logic               wvalid,
  input wire logic               wready,
  input wire logic               motion_start,
  input wire logic [3:0]         motion_action,
  input wire logic               position_clear,
  input wire logic               module_reset,
  input wire logic               relay_out
);
  logic       cmd_wr;
  logic [7:0] op;
  logic       clr_req;
  assign cmd_wr = awvalid && awready && wvalid && wready && awaddr == `REG_CMD && wstrb == 4'hf;
  assign op = wdata[`CMD_OP_HI:`CMD_OP_LO];
  always_ff @(posedge aclk) begin
    if (!aresetn) clr_req <= 1'b0;
    else clr_req <= cmd_wr && op == `OP_POS_CLR;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_start(logic [3:0] act);
    motion_start && motion_action == act ##1 !motion_start;
  endsequence
  sequence s_pulse_rst;
    module_reset ##1 !module_reset;
  endsequence
  a_soft_stop: assert property (cmd_wr && op == `OP_SOFT_STOP |=> s_start(4'h7))
    else $error("soft stop request missing");
  a_abrupt_hold_cmd: assert property (cmd_wr && op == `OP_ABRUPT_HOLD_CMD |=> s_start(4'h8))
    else $error("abrupt_hold_cmd request missing");
  a_decel_release: assert property (cmd_wr && op == `OP_DECEL_REL |=> s_start(4'h9))
    else $error("decel release request missing");
  a_abrupt_release: assert property (cmd_wr && op == `OP_ABRUPT_REL |=> s_start(4'ha))
    else $error("abrupt release request missing");
  a_module_reset: assert property (cmd_wr && op == `OP_MOD_RST |=> s_pulse_rst)
    else $error("module reset pulse missing");
  a_pos_clear: assert property (position_clear |-> clr_req)
    else $error("position clear without command");
  a_relay_cause: assert property ($changed(relay_out) |-> $past(cmd_wr))
    else $error("relay changed without command");
  a_unknown_op: assert property (cmd_wr && op == 8'h26 |=> !motion_start && !position_clear && !module_reset)
    else $error("unknown opcode had an effect");
endmodule // stepper_motion_cmd_executor_checker
bind stepper_motion_cmd_executor stepper_motion_cmd_executor_checker chk (.aclk(aclk), .aresetn(aresetn),
  .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
  .wready(wready), .motion_start(motion_start), .motion_action(motion_action),
  .position_clear(position_clear), .module_reset(module_reset), .relay_out(relay_out));

// ### tb/stepper_motion_cmd_executor_tb_top.sv
`timescale 1ns/100ps
`include "step_exec_params.svh"
module stepper_motion_cmd_executor_tb_top;
  typedef struct packed {logic [33:0] v; logic [33:0] m;} note_t;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, slow, motor_busy;
  logic        awready, wready, bvalid, arready, rvalid, motion_start, motion_reverse;
  logic        position_clear, module_reset, relay_out;
  logic [3:0]  awaddr, araddr, wstrb, motion_action, pins;
  logic [31:0] wdata, rdata, rnd;
  logic [1:0]  bresp, rresp;
  logic [21:0] motion_operand;
  note_t       bq[$], rq[$], mq[$];
  int          fails, samples_checked, cyc;
  logic [7:0]  t_op[10] = '{`OP_MOVE_F, `OP_MOVE_R_DEF, `OP_ABS_F, `OP_ABS_R, `OP_SHORTEST,
                            `OP_GO_ZERO, `OP_GO_MARK, `OP_ABRUPT_HOLD_CMD, `OP_DECEL_REL, `OP_ABRUPT_REL};
  logic [3:0]  t_act[10] = '{4'h1, 4'h1, 4'h2, 4'h2, 4'h3, 4'h5, 4'h6, 4'h8, 4'h9, 4'ha};
  logic        t_rev[10] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
  logic [33:0] t_m[10] = '{34'h1fffffff, 34'h1fffffff, 34'h1fffffff, 34'h1fffffff, 34'h1fbfffff,
                           34'h1f800000, 34'h1f800000, 34'h1f800000, 34'h1f800000, 34'h1f800000};
  stepper_motion_cmd_executor #(.MS_CYCLES(4)) dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .motor_busy(motor_busy), .motion_start(motion_start), .motion_action(motion_action),
    .motion_reverse(motion_reverse), .motion_operand(motion_operand), .position_clear(position_clear),
    .module_reset(module_reset), .relay_out(relay_out), .limit_switch_input(pins[3]),
    .zero_input(pins[2]), .digital_input_a(pins[0]), .digital_input_b(pins[1]));
  motion_model partner (.aclk(aclk), .aresetn(aresetn), .motion_start(motion_start),
    .motion_action(motion_action), .slow(slow), .motor_busy(motor_busy));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [33:0] mn(input logic [1:0] k, input logic [3:0] a, input logic r,
                                     input logic [21:0] o);
    return {5'h0, k, a, r, o};
  endfunction
  task complete_run;
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic take(ref note_t q[$], input logic [33:0] got);
    note_t n;
    if (q.size() == 0) begin
      fails++;
      $display("unexpected output at %0t: %h", $time, got);
    end else begin
      n = q.pop_front();
      samples_checked++;
      if ((got & n.m) !== (n.v & n.m)) begin
        fails++;
        $display("unexpected value at %0t: got %h want %h", $time, got, n.v);
      end
    end
  endtask
  task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
    bq.push_back('{{32'h0, r}, 34'h3});
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge aclk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    while (bvalid !== 1'b1) @(posedge aclk);
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic axr(input logic [3:0] a, input logic [33:0] v, input logic [33:0] m);
    rq.push_back('{v, m});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic st(input logic [31:0] v, input logic [31:0] m);
    axr(`REG_STATUS, {`RESP_OKAY, v}, {2'b11, m});
  endtask
  task automatic cmd(input logic [7:0] op, input logic [21:0] d, input logic [33:0] v, input logic [33:0] m);
    if (m != 34'h0) mq.push_back('{v, m});
    axw(`REG_CMD, {2'b00, op, d}, 4'hf, `RESP_OKAY);
  endtask
  task automatic clear_err;
    axw(`REG_STATUS, 32'h700, 4'h2, `RESP_OKAY);
  endtask
  always #4 aclk = ~aclk;
  // result watcher: every answer or request pops the oldest note
  always @(posedge aclk) begin
    if (aresetn) begin
      if (bvalid && bready) take(bq, {32'h0, bresp});
      if (rvalid && rready) take(rq, {rresp, rdata});
      if (motion_start || position_clear || module_reset)
        take(mq, {5'h0, module_reset, position_clear, motion_action, motion_reverse, motion_operand});
    end
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      $display("unexpected hang at %0t", $time);
      complete_run();
    end
  end
  initial begin
    aclk = 0; aresetn = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0; slow = 0;
    awaddr = 0; araddr = 0; wstrb = 0; wdata = 0; pins = 0; rnd = 32'h8f7b;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    st(32'h0, 32'hfffffffd);
    axr(`REG_MASK, {`RESP_OKAY, 32'hff}, 34'h3ffffffff);
    axr(4'hc, {`RESP_SLVERR, 32'h0}, 34'h3ffffffff);
    axw(4'hc, 32'h1, 4'hf, `RESP_SLVERR);
    cmd(`OP_RUN_F, `SPEED_MIN, mn(2'b00, 4'h0, 1'b0, `SPEED_MIN), 34'h1fffffff);
    cmd(`OP_SOFT_STOP, 22'h0, mn(2'b00, 4'h7, 1'b0, 22'h0), 34'h1f800000);
    cmd(`OP_RUN_R_DEF, `SPEED_MAX, mn(2'b00, 4'h0, 1'b1, `SPEED_MAX), 34'h1fffffff);
    cmd(`OP_RUN_F, 22'h00000e, 34'h0, 34'h0);
    cmd(`OP_RUN_R_DEF, 22'h003cf1, 34'h0, 34'h0);
    st(32'h200, 32'h200);
    clear_err();
    for (int i = 0; i < 10; i++) begin
      slow <= i[0];
      while (motor_busy !== 1'b0) @(posedge aclk);
      rnd = lfsr(rnd);
      cmd(t_op[i], rnd[21:0], mn(2'b00, t_act[i], t_rev[i], rnd[21:0]), t_m[i]);
    end
    cmd(`OP_POS_CLR, 22'h0, mn(2'b01, 4'h0, 1'b0, 22'h0), 34'h18000000);
    cmd(`OP_MOD_RST, 22'h0, mn(2'b10, 4'h0, 1'b0, 22'h0), 34'h18000000);
    cmd(`OP_RELAY_ON, 22'h0, 34'h0, 34'h0);
    st(32'h4, 32'h4);
    cmd(`OP_RELAY_OFF, 22'h0, 34'h0, 34'h0);
    st(32'h0, 32'h4);
    cmd(`OP_MASK, 22'h3fff5a, 34'h0, 34'h0);
    axr(`REG_MASK, {`RESP_OKAY, 32'h5a}, 34'h3ffffffff);
    for (int i = 0; i < 6; i++) begin
      axw(`REG_MASK, 32'hff & ~(32'h1 << (3 - i / 2)), 4'h1, `RESP_OKAY);
      cmd(`OP_UNTIL_F + 8'(i), 22'h64, mn(2'b00, i < 2 ? 4'h4 : 4'h0, i[0], 22'h64), 34'h1fffffff);
      pins <= 4'h1 << (3 - i / 2);
      repeat (8) @(posedge aclk);
      st(32'h1, 32'h1);
      mq.push_back('{mn(2'b00, 4'h7, 1'b0, 22'h0), 34'h1f800000});
      axw(`REG_MASK, 32'hff, 4'h1, `RESP_OKAY);
      repeat (8) @(posedge aclk);
      st(32'h0, 32'h1);
      pins <= 4'h0;
      @(posedge aclk);
    end
    for (int j = 0; j < 2; j++) begin
      cmd(`OP_AWAIT_A + 8'(j), 22'h0, 34'h0, 34'h0);
      cmd(`OP_RELAY_ON, 22'h0, 34'h0, 34'h0);
      st(32'h401, 32'h405);
      pins <= 4'h1 << j;
      repeat (6) @(posedge aclk);
      st(32'h0, 32'h1);
      pins <= 4'h0;
      clear_err();
    end
    cmd(`OP_PAUSE, 22'h3, 34'h0, 34'h0);
    st(32'h1, 32'h1);
    repeat (16) @(posedge aclk);
    st(32'h0, 32'h1);
    cmd(`OP_PAUSE, 22'h3, 34'h0, 34'h0);
    cmd(`OP_ABRUPT_HOLD_CMD, 22'h0, mn(2'b00, 4'h8, 1'b0, 22'h0), 34'h1f800000);
    st(32'h0, 32'h1);
    cmd(`OP_PAUSE, 22'h36ee81, 34'h0, 34'h0);
    st(32'h200, 32'h201);
    cmd(8'h26, 22'h0, 34'h0, 34'h0);
    st(32'h100, 32'h100);
    clear_err();
    repeat (5) @(posedge aclk);
    if (mq.size() != 0) begin
      fails++;
      $display("unexpected missing request at %0t", $time);
    end
    complete_run();
  end
endmodule // stepper_motion_cmd_executor_tb_top
